// *** rtl/module_pins_regs.svh ***
// register offsets, field positions, reset values and counts of the module pin block
// assumes inclusion by bare name from the package-importing design files
`ifndef MODULE_PINS_REGS_SVH
`define MODULE_PINS_REGS_SVH
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_ALARM 8'h08
`define OFF_MASK 8'h0C
`define CTRL_WIDTH 5
`define CTRL_RESET 5'h00
`define CTRL_BIT_CONTROL_MODE 0
`define CTRL_BIT_ALARM_MODE 1
`define CTRL_BIT_ALARM_ONE 2
`define CTRL_BIT_SW_TX_OFF 3
`define CTRL_BIT_SW_LOW_POWER 4
`define ST_BIT_TX_PIN 0
`define ST_BIT_POWER_PIN 1
`define ST_BIT_INIT_DONE 2
`define ST_BIT_SIGNAL_LOW 3
`define ST_BIT_TX_OFF 4
`define ST_BIT_LOW_POWER 5
`define ST_BIT_ALARM_LINE 6
`define ST_PORT_LSB 8
`define ALM_WIDTH 3
`define ALM_RESET 3'h0
`define ALM_BIT_SIGNAL_LOST 0
`define ALM_BIT_CONTROL_EDGE 1
`define ALM_BIT_POWER_CHANGE 2
`define SYNC_WIDTH 8
`define SYNC_RESET 8'hC3
`define SYN_TX 0
`define SYN_POWER 1
`define SYN_RESET 2
`define SYN_SIGNAL 3
`define SYN_PORT_LSB 4
`define SYN_ALARM_LINE 7
`define CLK_PERIOD_NS 4
`define INIT_TIME_NS 64
`define INIT_CYCLES ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_CNT_WIDTH 5
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define MDIO_PRE_BITS 6'h20
`define MDIO_HDR_LAST 6'h0D
`define MDIO_DATA_LAST 6'h0F
`define MDIO_START 2'h0
`define MDIO_PRTAD_HIGH 2'h0
`define MDIO_DEVAD 5'h01
`define MDIO_OP_ADDRESS 2'h0
`define MDIO_OP_WRITE 2'h1
`define MDIO_OP_READ 2'h3
`define MDIO_OP_READ_INC 2'h2
`endif

// *** rtl/module_pins_pkg.sv ***
// types shared by the module pin block and its management frame engine
// assumes nothing of its surroundings
package module_pins_pkg;
  typedef enum logic [1:0] {
    MDIO_PREAMBLE = 2'b00,
    MDIO_HEADER = 2'b01,
    MDIO_TURN = 2'b10,
    MDIO_DATA = 2'b11
  } mdio_state_type;
endpackage : module_pins_pkg

// *** rtl/mgmt_if.sv ***
// register access path from the management frame engine to the register file
// assumes both ends run on aclk
`timescale 1ns/10ps
interface mgmt_if;
  logic enable;
  logic [2:0] port_addr;
  logic wr;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport engine (input enable, input port_addr, input rdata,
                  output wr, output addr, output wdata);
  modport regs (output enable, output port_addr, output rdata, input wr, input addr, input wdata);
endinterface : mgmt_if

// *** rtl/mdio_frame_engine.sv ***
// management frame engine: serial frames on the management data line, sampled on clock rises
// assumes mdc and mdio arrive asynchronously and mdc is far slower than aclk
`timescale 1ns/10ps
`include "module_pins_regs.svh"
module mdio_frame_engine
  import module_pins_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic rst_n,
  // management pins
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // register path
  mgmt_if.engine m
);
  logic mdc_s1_r, mdc_s2_r, mdc_s3_r, dat_s1_r, dat_s2_r;
  mdio_state_type state_r;
  logic [5:0] cnt_r;
  logic [12:0] hdr_r;
  logic [15:0] shift_r;
  logic [15:0] addr_r;
  logic [1:0] op_r;
  logic hit_r, wr_r;
  logic rise;
  logic [13:0] hdr;
  logic [15:0] wdata_r;

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      {mdc_s1_r, mdc_s2_r, mdc_s3_r, dat_s1_r, dat_s2_r} <= 5'h00;
    end else begin
      {mdc_s1_r, mdc_s2_r, mdc_s3_r} <= {mdc_in, mdc_s1_r, mdc_s2_r};
      {dat_s1_r, dat_s2_r} <= {mdio_in, dat_s1_r};
    end
  end

  assign rise = mdc_s2_r & ~mdc_s3_r;
  assign hdr = {hdr_r, dat_s2_r};

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      state_r <= MDIO_PREAMBLE;
      cnt_r <= 6'h00;
      hdr_r <= 13'h0000;
      shift_r <= 16'h0000;
      addr_r <= 16'h0000;
      op_r <= `MDIO_OP_ADDRESS;
      hit_r <= 1'b0;
      wr_r <= 1'b0;
      wdata_r <= 16'h0000;
      mdio_out <= 1'b1;
      mdio_oe <= 1'b0;
    end else begin
      wr_r <= 1'b0;
      if (rise) begin
        case (state_r)
          MDIO_PREAMBLE: begin
            if (dat_s2_r) begin
              if (cnt_r != `MDIO_PRE_BITS) cnt_r <= cnt_r + 6'h01;
            end else if (cnt_r == `MDIO_PRE_BITS) begin
              state_r <= MDIO_HEADER;
              cnt_r <= 6'h01;
              hdr_r <= 13'h0000;
            end else begin
              cnt_r <= 6'h00;
            end
          end
          MDIO_HEADER: begin
            hdr_r <= hdr[12:0];
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == `MDIO_HDR_LAST) begin
              state_r <= MDIO_TURN;
              cnt_r <= 6'h00;
              op_r <= hdr[11:10];
              // only frames for this port and device are answered
              hit_r <= m.enable && hdr[13:12] == `MDIO_START &&
                       hdr[9:5] == {`MDIO_PRTAD_HIGH, m.port_addr} && hdr[4:0] == `MDIO_DEVAD;
              shift_r <= m.rdata;
            end
          end
          MDIO_TURN: begin
            cnt_r <= cnt_r + 6'h01;
            if (hit_r && op_r[1]) begin
              // read: drive zero in the second turnaround bit, then data
              mdio_oe <= 1'b1;
              mdio_out <= (cnt_r == 6'h00) ? 1'b0 : shift_r[15];
              if (cnt_r != 6'h00) shift_r <= {shift_r[14:0], 1'b0};
            end
            if (cnt_r != 6'h00) begin
              state_r <= MDIO_DATA;
              cnt_r <= 6'h00;
            end
          end
          MDIO_DATA: begin
            cnt_r <= cnt_r + 6'h01;
            if (cnt_r == `MDIO_DATA_LAST) begin
              state_r <= MDIO_PREAMBLE;
              cnt_r <= 6'h00;
              mdio_oe <= 1'b0;
              mdio_out <= 1'b1;
              if (hit_r && op_r == `MDIO_OP_ADDRESS) addr_r <= {shift_r[14:0], dat_s2_r};
              if (hit_r && op_r == `MDIO_OP_READ_INC) addr_r <= addr_r + 16'h0001;
              if (hit_r && op_r == `MDIO_OP_WRITE) begin
                wr_r <= 1'b1;
                wdata_r <= {shift_r[14:0], dat_s2_r};
              end
              hit_r <= 1'b0;
            end else if (hit_r && op_r[1]) begin
              mdio_out <= shift_r[15];
              shift_r <= {shift_r[14:0], 1'b0};
            end else begin
              shift_r <= {shift_r[14:0], dat_s2_r};
            end
          end
          default: state_r <= MDIO_PREAMBLE;
        endcase
      end
    end
  end

  assign m.wr = wr_r;
  assign m.addr = addr_r;
  assign m.wdata = wdata_r;

  default clocking @(posedge aclk); endclocking
  default disable iff (!rst_n);

  AST_MDIO_DRIVE_ONLY_READ: assert property (mdio_oe |-> hit_r && op_r[1])
    else $error("management line driven outside a matching read");
  AST_MDIO_RELEASE_IDLE: assert property (state_r == MDIO_PREAMBLE |-> !mdio_oe)
    else $error("management line still driven between frames");
  AST_MDIO_WRITE_PULSE: assert property (wr_r |=> !wr_r)
    else $error("register write pulse longer than one cycle");
endmodule : mdio_frame_engine

// *** rtl/module_control_pins.sv ***
// control and alarm pin logic of a pluggable optical module, AXI4-Lite register slave
// assumes host-side pins are asynchronous to aclk; bus master on aclk
// Functional notes
// - transmit disable pin high or open turns all lanes off; low turns them on
// - after reset the transmit disable pin may serve as programmable control one
// - signal-lost output high when received optical signal is low, else low
// - after reset signal-lost output may serve as programmable alarm one
// - open-drain global alarm pulled low while any alarm bit holds; host pulls up
// - low-power pin high or open keeps safe low-power mode; low allows full power
// - module reset pin low holds the module in reset; pull-down fitted inside
// - presence output tied low; host pull-up reads high when module absent
// - three port address pins from the host set the management port address
// - serial management interface with host clock and shared bidirectional data line
// - alarm, control and monitoring reach pins and management bus after initialization
`timescale 1ns/10ps
`include "module_pins_regs.svh"
module module_control_pins
  import module_pins_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // host control pins
  input wire logic transmit_disable_in,
  input wire logic low_power_select_in,
  input wire logic module_reset_in_n,
  input wire logic port_addr_bit0,
  input wire logic port_addr_bit1,
  input wire logic port_addr_bit2,
  // optics side
  input wire logic receive_signal_low_in,
  output logic [3:0] lane_tx_disable,
  output logic low_power_mode_out,
  // host status pins
  output logic receive_signal_lost_out,
  output logic programmable_control_one,
  input wire logic global_alarm_in_n,
  output logic global_alarm_out_n,
  output logic global_alarm_oe,
  output logic presence_out,
  // management pins
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe,
  // interrupt
  output logic irq
);
  localparam int INIT_WAIT = `INIT_CYCLES;
  logic [`SYNC_WIDTH-1:0] in_s1_r, in_s2_r;
  logic tx_pin_d_r, power_pin_d_r, signal_d_r;
  logic core_rst_n;
  logic [`INIT_CNT_WIDTH-1:0] init_cnt_r;
  logic init_done_r;
  logic [`CTRL_WIDTH-1:0] ctrl_r;
  logic [`ALM_WIDTH-1:0] alarm_r, mask_r, alarm_set, alarm_clr;
  logic control_mode, alarm_mode, tx_off_nxt, low_power_nxt;
  logic [31:0] status_value;
  logic [31:0] aw_addr_r, w_data_r;
  logic [3:0] w_strb_r;
  logic aw_full_r, w_full_r, axi_wr;
  logic [7:0] wr_off, mdio_off;
  logic mdio_in_map;
  mgmt_if m ();

  // two-flop synchronisers for every asynchronous pin except mdc_in and mdio_in, which the frame engine synchronises
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_s1_r <= `SYNC_RESET;
      in_s2_r <= `SYNC_RESET;
    end else begin
      in_s1_r <= {global_alarm_in_n, port_addr_bit2, port_addr_bit1, port_addr_bit0,
                  receive_signal_low_in, module_reset_in_n, low_power_select_in,
                  transmit_disable_in};
      in_s2_r <= in_s1_r;
    end
  end

  assign core_rst_n = aresetn & in_s2_r[`SYN_RESET];

  // initialization wait after every module reset
  always_ff @(posedge aclk) begin
    if (!core_rst_n) begin
      init_cnt_r <= '0;
      init_done_r <= 1'b0;
    end else if (!init_done_r) begin
      if (init_cnt_r == `INIT_CNT_WIDTH'(INIT_WAIT - 1)) init_done_r <= 1'b1;
      else init_cnt_r <= init_cnt_r + `INIT_CNT_WIDTH'(1);
    end
  end

  assign control_mode = init_done_r & ctrl_r[`CTRL_BIT_CONTROL_MODE];
  assign alarm_mode = init_done_r & ctrl_r[`CTRL_BIT_ALARM_MODE];
  assign tx_off_nxt = !init_done_r | ctrl_r[`CTRL_BIT_SW_TX_OFF] |
                      (!control_mode & in_s2_r[`SYN_TX]);
  assign low_power_nxt = !init_done_r | ctrl_r[`CTRL_BIT_SW_LOW_POWER] |
                         in_s2_r[`SYN_POWER];

  // pin outputs
  always_ff @(posedge aclk) begin
    if (!core_rst_n) begin
      lane_tx_disable <= 4'hF;
      low_power_mode_out <= 1'b1;
      receive_signal_lost_out <= 1'b0;
      programmable_control_one <= 1'b0;
    end else begin
      lane_tx_disable <= {4{tx_off_nxt}};
      low_power_mode_out <= low_power_nxt;
      receive_signal_lost_out <= alarm_mode ? ctrl_r[`CTRL_BIT_ALARM_ONE]
                                            : in_s2_r[`SYN_SIGNAL];
      programmable_control_one <= control_mode & in_s2_r[`SYN_TX];
    end
  end

  assign presence_out = 1'b0;
  assign global_alarm_out_n = 1'b0;

  // edge detectors for alarm events
  always_ff @(posedge aclk) begin
    if (!core_rst_n) begin
      tx_pin_d_r <= 1'b1;
      power_pin_d_r <= 1'b1;
      signal_d_r <= 1'b0;
    end else begin
      tx_pin_d_r <= in_s2_r[`SYN_TX];
      power_pin_d_r <= in_s2_r[`SYN_POWER];
      signal_d_r <= in_s2_r[`SYN_SIGNAL];
    end
  end

  always_comb begin
    alarm_set = '0;
    alarm_set[`ALM_BIT_SIGNAL_LOST] = in_s2_r[`SYN_SIGNAL] & !signal_d_r;
    alarm_set[`ALM_BIT_CONTROL_EDGE] = control_mode & (in_s2_r[`SYN_TX] != tx_pin_d_r);
    alarm_set[`ALM_BIT_POWER_CHANGE] = in_s2_r[`SYN_POWER] != power_pin_d_r;
    if (!init_done_r) alarm_set = '0;
  end

  // register writes from both the bus and the management frames
  assign axi_wr = aw_full_r & w_full_r & !bvalid;
  assign wr_off = {aw_addr_r[7:2], 2'b00};
  assign mdio_in_map = m.addr[15:6] == 10'h000;
  assign mdio_off = {m.addr[5:0], 2'b00};

  always_comb begin
    alarm_clr = '0;
    if (axi_wr && wr_off == `OFF_ALARM && aw_addr_r[31:8] == 24'h000000 && w_strb_r[0])
      alarm_clr = alarm_clr | w_data_r[`ALM_WIDTH-1:0];
    if (m.wr && mdio_in_map && mdio_off == `OFF_ALARM)
      alarm_clr = alarm_clr | m.wdata[`ALM_WIDTH-1:0];
  end

  always_ff @(posedge aclk) begin
    if (!core_rst_n) begin
      alarm_r <= `ALM_RESET;
    end else begin
      alarm_r <= (alarm_r & ~alarm_clr) | alarm_set;
    end
  end

  always_ff @(posedge aclk) begin
    if (!core_rst_n) begin
      ctrl_r <= `CTRL_RESET;
      mask_r <= `ALM_RESET;
    end else if (axi_wr && aw_addr_r[31:8] == 24'h000000 && w_strb_r[0]) begin
      if (wr_off == `OFF_CTRL) ctrl_r <= w_data_r[`CTRL_WIDTH-1:0];
      if (wr_off == `OFF_MASK) mask_r <= w_data_r[`ALM_WIDTH-1:0];
    end else if (m.wr && mdio_in_map) begin
      if (mdio_off == `OFF_CTRL) ctrl_r <= m.wdata[`CTRL_WIDTH-1:0];
      if (mdio_off == `OFF_MASK) mask_r <= m.wdata[`ALM_WIDTH-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!core_rst_n) begin
      global_alarm_oe <= 1'b0;
      irq <= 1'b0;
    end else begin
      global_alarm_oe <= |alarm_r;
      irq <= |(alarm_r & mask_r);
    end
  end

  always_comb begin
    status_value = 32'h0000_0000;
    status_value[`ST_BIT_TX_PIN] = in_s2_r[`SYN_TX];
    status_value[`ST_BIT_POWER_PIN] = in_s2_r[`SYN_POWER];
    status_value[`ST_BIT_INIT_DONE] = init_done_r;
    status_value[`ST_BIT_SIGNAL_LOW] = in_s2_r[`SYN_SIGNAL];
    status_value[`ST_BIT_TX_OFF] = lane_tx_disable[0];
    status_value[`ST_BIT_LOW_POWER] = low_power_mode_out;
    status_value[`ST_BIT_ALARM_LINE] = in_s2_r[`SYN_ALARM_LINE];
    status_value[`ST_PORT_LSB +: 3] = in_s2_r[`SYN_PORT_LSB +: 3];
  end

  function automatic logic [31:0] reg_value(input logic [7:0] off);
    reg_value = 32'h0000_0000;
    case (off)
      `OFF_CTRL: reg_value[`CTRL_WIDTH-1:0] = ctrl_r;
      `OFF_STATUS: reg_value = status_value;
      `OFF_ALARM: reg_value[`ALM_WIDTH-1:0] = alarm_r;
      `OFF_MASK: reg_value[`ALM_WIDTH-1:0] = mask_r;
      default: reg_value = 32'h0000_0000;
    endcase
  endfunction : reg_value

  function automatic logic mapped(input logic [31:0] a);
    mapped = a[31:8] == 24'h000000 && a[7:4] == 4'h0;
  endfunction : mapped

  // AXI4-Lite write channel: address and data taken in either order
  assign awready = !aw_full_r & !bvalid;
  assign wready = !w_full_r & !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 32'h0000_0000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_full_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end
      if (axi_wr) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= mapped(aw_addr_r) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read channel
  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= mapped(araddr) ? reg_value({araddr[7:2], 2'b00}) : 32'h0000_0000;
      rresp <= mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // management path
  always_ff @(posedge aclk) begin
    if (!core_rst_n) begin
      m.rdata <= 16'h0000;
    end else begin
      m.rdata <= mdio_in_map ? 16'(reg_value(mdio_off)) : 16'h0000;
    end
  end

  assign m.enable = init_done_r;
  assign m.port_addr = in_s2_r[`SYN_PORT_LSB +: 3];

  mdio_frame_engine u_engine (
    .aclk(aclk),
    .rst_n(core_rst_n),
    .mdc_in(mdc_in),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe(mdio_oe),
    .m(m)
  );

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_plain_tx_pin;
    init_done_r && !ctrl_r[`CTRL_BIT_CONTROL_MODE] && !ctrl_r[`CTRL_BIT_SW_TX_OFF];
  endsequence

  // in control mode the pin no longer turns the lanes off
  AST_TX_OFF_PIN: assert property (
    !control_mode && in_s2_r[`SYN_TX] && in_s2_r[`SYN_RESET] |=> lane_tx_disable == 4'hF)
    else $error("lanes not disabled while transmit disable pin high");
  AST_TX_ON_PIN: assert property (
    s_plain_tx_pin ##0 !in_s2_r[`SYN_TX] ##1 in_s2_r[`SYN_RESET] |-> lane_tx_disable == 4'h0)
    else $error("lanes not enabled while transmit disable pin low");
  AST_CONTROL_REUSE: assert property (
    control_mode && !ctrl_r[`CTRL_BIT_SW_TX_OFF] && in_s2_r[`SYN_RESET] |=>
      lane_tx_disable == 4'h0 && programmable_control_one == $past(in_s2_r[`SYN_TX]))
    else $error("programmable control does not follow the pin");
  AST_SIGNAL_LOST: assert property (
    !alarm_mode && in_s2_r[`SYN_RESET] |=>
      receive_signal_lost_out == $past(in_s2_r[`SYN_SIGNAL]))
    else $error("signal-lost output does not follow the optics");
  AST_ALARM_REUSE: assert property (
    alarm_mode && in_s2_r[`SYN_RESET] |=>
      receive_signal_lost_out == $past(ctrl_r[`CTRL_BIT_ALARM_ONE]))
    else $error("programmable alarm not shown on signal-lost output");
  AST_GLOBAL_ALARM: assert property (
    (|alarm_r) && in_s2_r[`SYN_RESET] |=> global_alarm_oe && !global_alarm_out_n)
    else $error("global alarm not pulled low with alarm pending");
  AST_LOW_POWER: assert property (in_s2_r[`SYN_POWER] |=> low_power_mode_out)
    else $error("low power mode left while select pin high");
  AST_MODULE_RESET: assert property (
    !in_s2_r[`SYN_RESET] |=> !init_done_r && lane_tx_disable == 4'hF && !irq)
    else $error("module reset pin low but module not held");
  AST_INIT_DONE: assert property (
    core_rst_n && !init_done_r && init_cnt_r == `INIT_CNT_WIDTH'(INIT_WAIT - 1) ##1
      core_rst_n |-> init_done_r)
    else $error("initialization did not complete on time");
endmodule : module_control_pins

// *** tb/host_model.sv ***
// host side of the module pins: pull-ups on the shared lines, idle management clock
// assumes the module drives its open-drain pins through separate enables
`timescale 1ns/10ps
`include "module_pins_regs.svh"
module host_model (
  // clock
  input wire logic aclk,
  // module side
  input wire logic global_alarm_oe,
  input wire logic global_alarm_out_n,
  input wire logic presence_out,
  input wire logic mdio_oe,
  input wire logic mdio_out,
  // resolved lines
  output logic alarm_line,
  output logic presence_line,
  output logic mdio_line,
  output logic mdc_line
);
  assign alarm_line = global_alarm_oe ? global_alarm_out_n : 1'b1;
  assign presence_line = presence_out;
  // vendor pins stay open and monitor clocks unused; clock stands still outside frames
  logic mdc_r = 1'b0, host_oe = 1'b0, host_bit = 1'b1;
  assign mdio_line = mdio_oe ? mdio_out : host_oe ? host_bit : 1'b1;
  assign mdc_line = mdc_r;
  // one frame: bits set up while the clock is low, line sampled just before each rise
  task automatic frame(input logic [1:0] op, input logic [4:0] prt, input logic [15:0] v,
                       output logic [15:0] got);
    logic [63:0] f;
    int i;
    f = {32'hFFFF_FFFF, `MDIO_START, op, prt, `MDIO_DEVAD, 2'b10, v};
    got = 16'h0000;
    for (i = 63; i >= 0; i--) begin
      @(posedge aclk);
      mdc_r <= 1'b0;
      host_oe <= !(op[1] && i < 18);
      host_bit <= f[i];
      repeat (4) @(posedge aclk);
      got = {got[14:0], mdio_line};
      mdc_r <= 1'b1;
      repeat (3) @(posedge aclk);
    end
    @(posedge aclk);
    mdc_r <= 1'b0;
    host_oe <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask : frame
endmodule : host_model

// *** tb/module_control_alarm_pins_bench.sv ***
// self-checking bench of the control and alarm pin block
// assumes the host model resolves the shared alarm and data lines
`timescale 1ns/10ps
`include "module_pins_regs.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module module_control_alarm_pins_bench;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, presence_line, irq, mdc_in, mdio_in, mdio_out, mdio_oe;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb, lane_tx_disable;
  logic [1:0] bresp, rresp;
  logic transmit_disable_in, low_power_select_in, module_reset_in_n, receive_signal_low_in;
  logic port_addr_bit0, port_addr_bit1, port_addr_bit2, low_power_mode_out;
  logic receive_signal_lost_out, programmable_control_one, global_alarm_in_n;
  logic global_alarm_out_n, global_alarm_oe, presence_out;
  logic [31:0] d;
  int n_errors, comparisons;
  module_control_pins i_module_control_pins (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .transmit_disable_in, .low_power_select_in,
    .module_reset_in_n, .port_addr_bit0, .port_addr_bit1, .port_addr_bit2,
    .receive_signal_low_in, .lane_tx_disable, .low_power_mode_out, .receive_signal_lost_out,
    .programmable_control_one, .global_alarm_in_n, .global_alarm_out_n, .global_alarm_oe,
    .presence_out, .mdc_in, .mdio_in, .mdio_out, .mdio_oe, .irq);
  host_model i_host_model (.aclk, .global_alarm_oe, .global_alarm_out_n, .presence_out, .mdio_oe,
    .mdio_out, .alarm_line(global_alarm_in_n), .presence_line, .mdio_line(mdio_in),
    .mdc_line(mdc_in));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic stop_test;
    $display("counts: %0d mismatches, %0d comparisons", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test
  task automatic timeout(input int n);
    if (n >= 40) begin
      n_errors++;
      $display("[ERR] handshake timeout");
      stop_test();
    end
  endtask : timeout
  // readies and answers are looked at mid-cycle, the transfer happens at the next rise
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    int n;
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= {24'h000000, a};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    for (n = 0; n < 40 && !tb; n++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      if (tb) `CHK("bresp", er, bresp)
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
    timeout(n);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    int n;
    logic ta, tr;
    @(posedge aclk);
    araddr <= {24'h000000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    for (n = 0; n < 40 && !tr; n++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      if (tr) d = rdata;
      if (tr) `CHK("rresp", er, rresp)
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
    timeout(n);
  endtask : rd
  task automatic settle;
    repeat (8) @(posedge aclk);
  endtask : settle
  task automatic wait_init;
    int n;
    d = 32'h00000000;
    for (n = 0; n < 40 && d[`ST_BIT_INIT_DONE] !== 1'b1; n++) rd(`OFF_STATUS, `RESP_OKAY);
    timeout(n);
  endtask : wait_init
  task automatic t_reset;
    `CHK("lanes", 4'hF, lane_tx_disable)
    `CHK("lowpwr", 1'b1, low_power_mode_out)
    `CHK("present", 1'b0, presence_line)
    `CHK("alarm oe", 1'b0, global_alarm_oe)
    wait_init();
    rd(`OFF_CTRL, `RESP_OKAY);
    `CHK("ctrl", 32'h00000000, d)
    $display("done t_reset");
  endtask : t_reset
  task automatic t_tx;
    @(posedge aclk);
    transmit_disable_in <= 1'b0;
    low_power_select_in <= 1'b0;
    settle();
    `CHK("lanes on", 4'h0, lane_tx_disable)
    `CHK("full pwr", 1'b0, low_power_mode_out)
    wr(`OFF_CTRL, 32'h00000018, `RESP_OKAY);
    settle();
    `CHK("sw off", 4'hF, lane_tx_disable)
    wr(`OFF_CTRL, 32'h00000000, `RESP_OKAY);
    transmit_disable_in <= 1'b1;
    low_power_select_in <= 1'b1;
    settle();
    `CHK("lanes off", 4'hF, lane_tx_disable)
    `CHK("low pwr", 1'b1, low_power_mode_out)
    wr(`OFF_ALARM, 32'h00000007, `RESP_OKAY);
    $display("done t_tx");
  endtask : t_tx
  task automatic t_alarm;
    wr(`OFF_MASK, 32'h00000001, `RESP_OKAY);
    receive_signal_low_in <= 1'b1;
    settle();
    `CHK("lost", 1'b1, receive_signal_lost_out)
    `CHK("alarm line", 1'b0, global_alarm_in_n)
    `CHK("irq", 1'b1, irq)
    receive_signal_low_in <= 1'b0;
    settle();
    `CHK("lost clr", 1'b0, receive_signal_lost_out)
    `CHK("sticky", 1'b1, global_alarm_oe)
    wr(`OFF_ALARM, 32'h00000001, `RESP_OKAY);
    wr(`OFF_MASK, 32'h00000000, `RESP_OKAY);
    settle();
    `CHK("alarm clr", 1'b1, global_alarm_in_n)
    receive_signal_low_in <= 1'b1;
    settle();
    `CHK("masked irq", 1'b0, irq)
    `CHK("masked line", 1'b0, global_alarm_in_n)
    receive_signal_low_in <= 1'b0;
    wr(`OFF_ALARM, 32'h00000001, `RESP_OKAY);
    $display("done t_alarm");
  endtask : t_alarm
  task automatic t_modes;
    wr(`OFF_CTRL, 32'h00000001, `RESP_OKAY);
    transmit_disable_in <= 1'b0;
    settle();
    `CHK("pctl lo", 1'b0, programmable_control_one)
    transmit_disable_in <= 1'b1;
    settle();
    `CHK("pctl hi", 1'b1, programmable_control_one)
    rd(`OFF_ALARM, `RESP_OKAY);
    `CHK("edge alarm", 32'h00000002, d)
    wr(`OFF_CTRL, 32'h00000006, `RESP_OKAY);
    settle();
    `CHK("palarm", 1'b1, receive_signal_lost_out)
    wr(`OFF_CTRL, 32'h00000000, `RESP_OKAY);
    wr(`OFF_ALARM, 32'h00000007, `RESP_OKAY);
    $display("done t_modes");
  endtask : t_modes
  task automatic t_misc;
    port_addr_bit0 <= 1'b1;
    port_addr_bit2 <= 1'b1;
    low_power_select_in <= 1'b0;
    settle();
    rd(`OFF_STATUS, `RESP_OKAY);
    `CHK("port", 3'h5, d[10:8])
    wr(8'h10, 32'h000000FF, `RESP_SLVERR);
    rd(8'h10, `RESP_SLVERR);
    `CHK("unmapped", 32'h00000000, d)
    wr(`OFF_CTRL, 32'h00000008, `RESP_OKAY);
    module_reset_in_n <= 1'b0;
    settle();
    `CHK("rst lowpwr", 1'b1, low_power_mode_out)
    rd(`OFF_CTRL, `RESP_OKAY);
    `CHK("rst ctrl", 32'h00000000, d)
    module_reset_in_n <= 1'b1;
    wait_init();
    $display("done t_misc");
  endtask : t_misc
  task automatic t_mdio;
    logic [15:0] g;
    i_host_model.frame(`MDIO_OP_ADDRESS, 5'h05, 16'h0000, g);
    i_host_model.frame(`MDIO_OP_WRITE, 5'h05, 16'h0008, g);
    i_host_model.frame(`MDIO_OP_WRITE, 5'h04, 16'h0000, g);
    rd(`OFF_CTRL, `RESP_OKAY);
    `CHK("mdio wr", 32'h00000008, d)
    i_host_model.frame(`MDIO_OP_READ_INC, 5'h05, 16'h0000, g);
    `CHK("mdio rd", 16'h0008, g)
    i_host_model.frame(`MDIO_OP_WRITE, 5'h05, 16'h0000, g);
    rd(`OFF_CTRL, `RESP_OKAY);
    `CHK("mdio inc", 32'h00000008, d)
    $display("done t_mdio");
  endtask : t_mdio
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, receive_signal_low_in} = 6'h00;
    {port_addr_bit0, port_addr_bit1, port_addr_bit2} = 3'h0;
    {transmit_disable_in, low_power_select_in, module_reset_in_n} = 3'h7;
    awaddr = 32'h00000000;
    araddr = 32'h00000000;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    aresetn = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_tx();
    t_alarm();
    t_modes();
    t_misc();
    t_mdio();
    stop_test();
  end
endmodule : module_control_alarm_pins_bench
